// *** design/key_irq_pkg.sv ***
package key_irq_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ      = 50_000_000;  // System clock rate
  localparam int TICK_US     = 1000;        // Debounce tick, 1 ms
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int DEB_W       = 6;           // Timer spans 0..63 ms

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_KEY_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_KEY_PINS   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DEBOUNCE   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PIN_CTRL   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_PIN_SEL0   = 8'h10;  // One word per generator
  localparam logic [ADDR_W-1:0] OFF_PIN_CLEAR  = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_PIN_FLAGS  = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_STATUS     = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_MASK       = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_PORT_VALUE = 8'h34;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int KC_LEVEL_BIT = 0;
  localparam int KC_REL_BIT   = 1;
  localparam int KC_DEBON_BIT = 2;
  localparam int KC_REP_LSB   = 8;
  localparam int DB_GEN_LSB   = 8;
  localparam int PC_EDGE_LSB  = 8;

  // ---------------------------------------------------------------
  // Reset values and bus answers
  // ---------------------------------------------------------------
  localparam logic [DEB_W-1:0] RST_DEBOUNCE_LOAD_VALUE  = 6'h00;
  localparam logic [DEB_W-1:0] RST_KEY_REPEAT = 6'h00;
  localparam logic [1:0]       RESP_OKAY      = 2'h0;
  localparam logic [1:0]       RESP_SLVERR    = 2'h2;

  // ---------------------------------------------------------------
  // State machines
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {K_IDLE, K_PRESS, K_HELD, K_REL} key_state_t;
  typedef enum logic [1:0] {P_IDLE, P_DEB, P_FLAG, P_WAIT} pin_state_t;

endpackage : key_irq_pkg

// *** design/key_debounce_pin_irq.sv ***
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
// Functional notes
// - Active-low level: falling edge on an enabled key pin starts the key machine.
// - Key trigger loads debounce value; timer decrements once per 1 ms tick.
// - Expiry with key still hit: key interrupt, reload repeat value, repeat.
// - With release reporting on, release starts debounce, then one key interrupt.
// - Key debounce disabled: the debounce delay is bypassed.
// - Repeat value zero: no repeated key interrupts while held.
// - Level bit sets key polarity; release reporting off when its bit is clear.
// - A key pin joins scanning only when its enable bit is set; 24 pins.
// - Debounce covers 0 to 63 ms.
// - Five pin generators, each with own source select among 32 pins.
// - Polarity clear: high level on selected pin starts the generator; edge mode needs a rising transition.
// - Generator debounces with shared value; flags only if match holds at zero.
// - Each generator has its own debounce enable; clear means no delay.
// - Pin flag stays set until software writes its clear bit.
// - Edge mode: clear moves to wait-for-release; idle once the match is inactive.
module key_debounce_pin_irq
  import key_irq_pkg::*;
#(
  parameter int TICK_DIV  = TICK_CYCLES,
  parameter int KEY_PINS  = 24,
  parameter int PIN_COUNT = 32,
  parameter int NUM_GEN   = 5
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // General purpose pins
  input  wire logic [PIN_COUNT-1:0] pin_in,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Interrupts
  output logic                      key_scan_irq,
  output logic [NUM_GEN-1:0]        pin_event_irq,
  output logic                      irq
);

  localparam int SEL_W  = $clog2(PIN_COUNT);
  localparam int STAT_W = NUM_GEN + 1;
  localparam int TW     = $clog2(TICK_DIV + 1);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [PIN_COUNT-1:0] pins_m;
  logic [PIN_COUNT-1:0] pins_s;
  logic [TW-1:0]        tick_cnt;
  logic                 tick;
  logic                 key_active_level;
  logic                 release_irq_enable;
  logic                 key_debounce_on;
  logic [DEB_W-1:0]     key_rep;
  logic [KEY_PINS-1:0]  key_pin_select_bits;
  logic [DEB_W-1:0]     debounce_load_value;
  logic [NUM_GEN-1:0]   pin_irq_debounce_on;
  logic [NUM_GEN-1:0]   pin_irq_polarity;
  logic [NUM_GEN-1:0]   pin_irq_edge_mode;
  logic [SEL_W-1:0]     pin_irq_source_select [NUM_GEN];
  logic [STAT_W-1:0]    irq_status;
  logic [STAT_W-1:0]    irq_mask;
  logic [NUM_GEN-1:0]   pin_set;
  logic [NUM_GEN-1:0]   pin_clr;
  key_state_t           key_state;
  logic [DEB_W-1:0]     key_timer;
  logic [DEB_W-1:0]     key_load;
  logic [KEY_PINS-1:0]  key_lvl_pins;
  logic                 key_hit;
  logic                 key_hit_d;
  logic                 key_rise;
  logic                 aw_held;
  logic                 w_held;
  logic [ADDR_W-1:0]    aw_addr;
  logic [31:0]          wdata;
  logic [3:0]           wstrb;
  logic                 do_write;
  logic [31:0]          bmask;
  logic [32:0]          wr_old;
  logic [31:0]          wr_word;
  logic [32:0]          rd_word;
  logic                 stat_rd_clr;

  function automatic logic [ADDR_W-1:0] sel_off(input int i);
    return ADDR_W'(OFF_PIN_SEL0 + 4 * i);
  endfunction : sel_off

  // Register read view; bit 32 flags a mapped address
  function automatic logic [32:0] reg_read(input logic [ADDR_W-1:0] a);
    logic [32:0] r;
    r = '0;
    r[32] = 1'b1;
    case (a)
      OFF_KEY_CTRL: begin
        r[KC_LEVEL_BIT] = key_active_level;
        r[KC_REL_BIT]   = release_irq_enable;
        r[KC_DEBON_BIT] = key_debounce_on;
        r[KC_REP_LSB +: DEB_W] = key_rep;
      end
      OFF_KEY_PINS:   r[KEY_PINS-1:0] = key_pin_select_bits;
      OFF_DEBOUNCE: begin
        r[DEB_W-1:0] = debounce_load_value;
        r[DB_GEN_LSB +: NUM_GEN] = pin_irq_debounce_on;
      end
      OFF_PIN_CTRL: begin
        r[NUM_GEN-1:0] = pin_irq_polarity;
        r[PC_EDGE_LSB +: NUM_GEN] = pin_irq_edge_mode;
      end
      OFF_PIN_CLEAR:  r[31:0] = '0;  // Write-only, reads zero
      OFF_PIN_FLAGS:  r[NUM_GEN-1:0] = pin_event_irq;
      OFF_STATUS:     r[STAT_W-1:0] = irq_status;
      OFF_MASK:       r[STAT_W-1:0] = irq_mask;
      OFF_PORT_VALUE: r[PIN_COUNT-1:0] = pins_s;
      default: begin
        r[32] = 1'b0;
        for (int i = 0; i < NUM_GEN; i++) begin
          if (a == sel_off(i)) begin
            r[32] = 1'b1;
            r[SEL_W-1:0] = pin_irq_source_select[i];
          end
        end
      end
    endcase
    return r;
  endfunction : reg_read

  // ---------------------------------------------------------------
  // Pin synchroniser and 1 ms prescaler
  // ---------------------------------------------------------------
  // Pins are asynchronous; only pins_s is read by logic
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pins_m <= '0;
      pins_s <= '0;
    end else begin
      pins_m <= pin_in;
      pins_s <= pins_m;
    end
  end

  // One-cycle tick every millisecond; the first tick after a load may
  // come early, so a programmed delay of N ms lasts N-1 to N ms
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == TW'(TICK_DIV - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  assign do_write    = aw_held & w_held;
  assign bmask       = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  assign wr_word     = (wr_old[31:0] & ~bmask) | (wdata & bmask);
  assign stat_rd_clr = s_axi_arvalid & s_axi_arready & (s_axi_araddr == OFF_STATUS);
  assign pin_clr     = (do_write && aw_addr == OFF_PIN_CLEAR) ? wr_word[NUM_GEN-1:0] : '0;

  // Register views; a plain assign would wake only on the address, so a
  // second read of the same address would return a stale word
  always_comb begin
    wr_old  = reg_read(aw_addr);
    rd_word = reg_read(s_axi_araddr);
  end

  // Address and data are taken in either order, then answered together
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      wdata         <= '0;
      wstrb         <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata        <= s_axi_wdata;
        wstrb        <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_old[32] ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Reads answer one cycle after the address is taken
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word[31:0];
        s_axi_rresp   <= rd_word[32] ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Control registers; byte strobes merge into the current value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      key_active_level    <= 1'b0;
      release_irq_enable  <= 1'b0;
      key_debounce_on     <= 1'b0;
      key_rep             <= RST_KEY_REPEAT;
      key_pin_select_bits <= '0;
      debounce_load_value <= RST_DEBOUNCE_LOAD_VALUE;
      pin_irq_debounce_on <= '0;
      pin_irq_polarity    <= '0;
      pin_irq_edge_mode   <= '0;
      irq_mask            <= '0;
      for (int i = 0; i < NUM_GEN; i++) begin
        pin_irq_source_select[i] <= '0;
      end
    end else if (do_write) begin
      case (aw_addr)
        OFF_KEY_CTRL: begin
          key_active_level   <= wr_word[KC_LEVEL_BIT];
          release_irq_enable <= wr_word[KC_REL_BIT];
          key_debounce_on    <= wr_word[KC_DEBON_BIT];
          key_rep            <= wr_word[KC_REP_LSB +: DEB_W];
        end
        OFF_KEY_PINS: key_pin_select_bits <= wr_word[KEY_PINS-1:0];
        OFF_DEBOUNCE: begin
          debounce_load_value <= wr_word[DEB_W-1:0];
          pin_irq_debounce_on <= wr_word[DB_GEN_LSB +: NUM_GEN];
        end
        OFF_PIN_CTRL: begin
          pin_irq_polarity  <= wr_word[NUM_GEN-1:0];
          pin_irq_edge_mode <= wr_word[PC_EDGE_LSB +: NUM_GEN];
        end
        OFF_MASK: irq_mask <= wr_word[STAT_W-1:0];
        default: begin
          for (int i = 0; i < NUM_GEN; i++) begin
            if (aw_addr == sel_off(i)) begin
              pin_irq_source_select[i] <= wr_word[SEL_W-1:0];
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------
  // Read clears, but an event in the same cycle survives the clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else begin
      irq_status <= (stat_rd_clr ? '0 : irq_status) | {pin_set, key_scan_irq};
      irq        <= |(irq_status & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // Keyboard scanner
  // ---------------------------------------------------------------
  assign key_lvl_pins = key_active_level ? pins_s[KEY_PINS-1:0] : ~pins_s[KEY_PINS-1:0];
  assign key_hit      = |(key_lvl_pins & key_pin_select_bits);
  assign key_rise     = key_hit & ~key_hit_d;
  assign key_load     = key_debounce_on ? debounce_load_value : '0;

  // Bypass loads zero, so the check happens on the very next cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      key_state    <= K_IDLE;
      key_timer    <= '0;
      key_hit_d    <= 1'b0;
      key_scan_irq <= 1'b0;
    end else begin
      key_hit_d    <= key_hit;
      key_scan_irq <= 1'b0;
      unique case (key_state)
        K_IDLE: begin
          if (key_rise) begin
            key_timer <= key_load;
            key_state <= K_PRESS;
          end
        end
        K_PRESS: begin
          if (key_timer == '0) begin
            if (key_hit) begin
              key_scan_irq <= 1'b1;
              key_timer    <= key_rep;
              key_state    <= K_HELD;
            end else begin
              key_state <= K_IDLE;  // Glitch shorter than the debounce
            end
          end else if (tick) begin
            key_timer <= key_timer - 1'b1;
          end
        end
        K_HELD: begin
          if (!key_hit) begin
            if (release_irq_enable) begin
              key_timer <= key_load;
              key_state <= K_REL;
            end else begin
              key_state <= K_IDLE;
            end
          end else if (key_rep != '0) begin
            if (key_timer == '0) begin
              key_scan_irq <= 1'b1;
              key_timer    <= key_rep;
            end else if (tick) begin
              key_timer <= key_timer - 1'b1;
            end
          end
        end
        K_REL: begin
          if (key_timer == '0) begin
            key_scan_irq <= 1'b1;
            key_state    <= K_IDLE;
          end else if (tick) begin
            key_timer <= key_timer - 1'b1;
          end
        end
      endcase
    end
  end

  AST_KEY_START: assert property (@(posedge clk) disable iff (!rstn)
    key_state == K_IDLE && key_rise |=> key_state == K_PRESS)
    else $error("key press did not start debounce");

  AST_KEY_LOAD: assert property (@(posedge clk) disable iff (!rstn)
    key_state == K_IDLE && key_rise |=> key_timer == $past(key_load))
    else $error("key timer not loaded with debounce value");

  AST_KEY_DEC: assert property (@(posedge clk) disable iff (!rstn)
    key_state == K_PRESS && key_timer != '0 && tick
    |=> key_timer == $past(key_timer) - 1'b1)
    else $error("key timer did not count down on tick");

  AST_KEY_FIRE: assert property (@(posedge clk) disable iff (!rstn)
    key_state == K_PRESS && key_timer == '0 && key_hit
    |=> key_scan_irq && key_state == K_HELD ##1 !key_scan_irq)
    else $error("key interrupt missing after debounce");

  AST_KEY_NOREP: assert property (@(posedge clk) disable iff (!rstn)
    key_state == K_HELD && key_hit && key_rep == '0 |=> !key_scan_irq)
    else $error("repeat interrupt with zero repeat value");

  AST_KEY_NOREL: assert property (@(posedge clk) disable iff (!rstn)
    key_state == K_HELD && !key_hit && !release_irq_enable
    |=> key_state == K_IDLE ##1 !key_scan_irq)
    else $error("release reported while disabled");

  AST_KEY_REL: assert property (@(posedge clk) disable iff (!rstn)
    key_state == K_REL && key_timer == '0 |=> key_scan_irq && key_state == K_IDLE)
    else $error("release interrupt missing");

  // ---------------------------------------------------------------
  // Pin interrupt generators
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NUM_GEN; g++) begin : gen_pin
    pin_state_t       st;
    logic [DEB_W-1:0] tmr;
    logic             mt;
    logic             mt_d;
    logic             start;
    logic             flag;
    logic             set_p;

    assign mt    = pins_s[pin_irq_source_select[g]] ^ pin_irq_polarity[g];
    assign start = pin_irq_edge_mode[g] ? (mt & ~mt_d) : mt;
    assign pin_event_irq[g] = flag;
    assign pin_set[g]       = set_p;

    // Level mode re-enters debounce from idle while the level persists
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        st    <= P_IDLE;
        tmr   <= '0;
        mt_d  <= 1'b0;
        flag  <= 1'b0;
        set_p <= 1'b0;
      end else begin
        mt_d  <= mt;
        set_p <= 1'b0;
        unique case (st)
          P_IDLE: begin
            if (start) begin
              tmr <= pin_irq_debounce_on[g] ? debounce_load_value : '0;
              st  <= P_DEB;
            end
          end
          P_DEB: begin
            if (tmr == '0) begin
              if (mt) begin
                flag  <= 1'b1;
                set_p <= 1'b1;
                st    <= P_FLAG;
              end else begin
                st <= P_IDLE;
              end
            end else if (tick) begin
              tmr <= tmr - 1'b1;
            end
          end
          P_FLAG: begin
            if (pin_clr[g]) begin
              flag <= 1'b0;
              st   <= pin_irq_edge_mode[g] ? P_WAIT : P_IDLE;
            end
          end
          P_WAIT: begin
            if (!mt) begin
              st <= P_IDLE;
            end
          end
        endcase
      end
    end

    AST_PIN_SET: assert property (@(posedge clk) disable iff (!rstn)
      st == P_DEB && tmr == '0 && mt |=> flag && set_p ##1 !set_p)
      else $error("pin flag not set after debounce");

    AST_PIN_NOSET: assert property (@(posedge clk) disable iff (!rstn)
      st == P_DEB && tmr == '0 && !mt |=> !flag && st == P_IDLE)
      else $error("pin flag set without match");

    AST_PIN_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      flag && !pin_clr[g] |=> flag)
      else $error("pin flag dropped without clear");

    AST_PIN_WAIT: assert property (@(posedge clk) disable iff (!rstn)
      st == P_FLAG && pin_clr[g] && pin_irq_edge_mode[g] |=> st == P_WAIT && !flag)
      else $error("edge mode clear did not wait for release");
  end

endmodule : key_debounce_pin_irq

// *** tb/key_pin_model.sv ***
`timescale 1ns/100ps
// Keys and switches on the pins; they settle off the clock edge, like real contacts
module key_pin_model (
  // Contact state asked for by the bench
  input  wire logic [31:0] level,
  // Pins seen by the block
  output logic      [31:0] pins
);
  // Skew against the clock so the synchroniser meets an asynchronous change
  assign #3 pins = level;
endmodule : key_pin_model

// *** tb/key_debounce_pin_irq_tb_top.sv ***
`timescale 1ns/100ps
module key_debounce_pin_irq_tb_top;
  import key_irq_pkg::*;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic        clk = 0, rstn = 0;
  logic [31:0] keys = 0, pin_in, s_axi_wdata = 0, s_axi_rdata, v;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        key_scan_irq, irq;
  logic [4:0]  pin_event_irq;
  logic [33:0] notes[$];
  int          err_total = 0, cmp_count = 0, kcnt = 0, k0, cyc = 0, seed = 32'h1e26;
  key_pin_model i_key_pin_model (.level(keys), .pins(pin_in));
  key_debounce_pin_irq #(.TICK_DIV(20)) i_key_debounce_pin_irq (.clk, .rstn, .pin_in,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .key_scan_irq, .pin_event_irq, .irq);
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  // Ready is sampled mid-cycle; it is registered, so it equals the value at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ra, rw, rb;
    logic [1:0] br;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(negedge clk);
      ra = s_axi_awready & s_axi_awvalid;
      rw = s_axi_wready & s_axi_wvalid;
      rb = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge clk);
      if (ra) s_axi_awvalid <= 1'h0;
      if (rw) s_axi_wvalid <= 1'h0;
    end while (!rb);
    s_axi_bready <= 1'h0;
    check("bresp", 34'(br), 34'(er));
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic ra, rv;
    notes.push_back(e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(negedge clk);
      ra = s_axi_arready & s_axi_arvalid;
      rv = s_axi_rvalid;
      @(posedge clk);
      if (ra) s_axi_arvalid <= 1'h0;
    end while (!rv);
    s_axi_rready <= 1'h0;
    @(posedge clk);
  endtask : rd
  // ---------------------------------------------------------------
  // Clock, watchers and timeout
  // ---------------------------------------------------------------
  initial forever #10 clk = ~clk;
  // Read answers are matched against the oldest note
  always @(negedge clk) if (s_axi_rvalid && s_axi_rready) check("rdata", {s_axi_rresp, s_axi_rdata}, notes.pop_front());
  always @(posedge clk) begin
    if (key_scan_irq === 1'h1) kcnt <= kcnt + 1;
    cyc <= cyc + 1;
    // Whole run needs about 1100 cycles
    if (cyc == 10000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // Main sequence: registers, pin generators, then key scanner
  initial begin
    idle(6);
    rstn <= 1'h1;
    idle(3);
    rd(OFF_MASK, {RESP_OKAY, 32'h0});
    rd(8'h3c, {RESP_SLVERR, 32'h0});
    wr(8'h3c, 32'h1, RESP_SLVERR);
    for (int g = 0; g < 5; g++) wr(8'(OFF_PIN_SEL0 + 4 * g), 32'(24 + g), RESP_OKAY);
    wr(OFF_DEBOUNCE, 32'h203, RESP_OKAY);
    wr(OFF_PIN_CTRL, 32'h400, RESP_OKAY);
    wr(OFF_MASK, 32'h3f, RESP_OKAY);
    v = $random(seed);
    keys <= {8'h00, v[23:0]};
    idle(4);
    rd(OFF_PORT_VALUE, {RESP_OKAY, 8'h00, v[23:0]});
    keys[25] <= 1'h1;
    idle(5);
    keys[25] <= 1'h0;
    idle(80);
    check("flags", 34'(pin_event_irq), 34'h0);
    keys[26:24] <= 3'h7;
    idle(8);
    check("flags", 34'(pin_event_irq), 34'h5);
    idle(80);
    check("flags", 34'(pin_event_irq), 34'h7);
    check("irq", 34'(irq), 34'h1);
    rd(OFF_STATUS, {RESP_OKAY, 32'he});
    rd(OFF_STATUS, {RESP_OKAY, 32'h0});
    idle(3);
    check("irq", 34'(irq), 34'h0);
    wr(OFF_PIN_CLEAR, 32'h7, RESP_OKAY);
    idle(8);
    check("flags", 34'(pin_event_irq), 34'h1);
    wr(OFF_PIN_CTRL, 32'h404, RESP_OKAY);
    idle(4);
    keys[26] <= 1'h0;
    idle(8);
    check("flags", 34'(pin_event_irq), 34'h5);
    keys[4:3] <= 2'h3;
    wr(OFF_KEY_PINS, 32'h8, RESP_OKAY);
    wr(OFF_KEY_CTRL, 32'h6, RESP_OKAY);
    idle(10);
    k0 = kcnt;
    keys[4] <= 1'h0;
    idle(100);
    check("key irq", 34'(kcnt - k0), 34'h0);
    keys[3] <= 1'h0;
    idle(30);
    check("key irq", 34'(kcnt - k0), 34'h0);
    idle(170);
    check("key irq", 34'(kcnt - k0), 34'h1);
    keys[3] <= 1'h1;
    idle(100);
    check("key irq", 34'(kcnt - k0), 34'h2);
    wr(OFF_KEY_CTRL, 32'h304, RESP_OKAY);
    k0 = kcnt;
    keys[3] <= 1'h0;
    idle(300);
    check("key repeat", 34'(kcnt - k0 >= 4), 34'h1);
    keys[3] <= 1'h1;
    idle(5);
    k0 = kcnt;
    idle(100);
    check("key irq", 34'(kcnt - k0), 34'h0);
    wr(OFF_KEY_CTRL, 32'h0, RESP_OKAY);
    k0 = kcnt;
    keys[3] <= 1'h0;
    idle(10);
    check("key irq", 34'(kcnt - k0), 34'h1);
    wr(OFF_KEY_CTRL, 32'h1, RESP_OKAY);
    k0 = kcnt;
    keys[3] <= 1'h1;
    idle(10);
    check("key irq", 34'(kcnt - k0), 34'h1);
    tally_and_finish();
  end
endmodule : key_debounce_pin_irq_tb_top
